// ### design/mlp_unit.v
// Multiply, OR and pattern compare execution slice of a 32-bit core.
// Assumes register file reads are presented with the instruction and
// results are written back from res_* outputs.
`timescale 1ns/1ps
`include "mlp_map.vh"

// Functional notes
// - Upper-unsigned multiply writes high word of unsigned 64-bit product.
// - Mixed multiply: first signed, second unsigned, high word written.
// - Constant multiply writes low word of source times extended constant.
// - Multiplies take 1 cycle normally, 3 cycles in area mode.
// - Upper-word multiplies exist only with multiplier option 2.
// - Constant multiply exists when multiplier option exceeds 0.
// - Bits 30 and 31 select among register multiply variants.
// - Constant sign-extended from 16 bits, unless prefixed by upper half.
// - Register OR writes bitwise OR in one cycle.
// - Constant OR writes OR with extended constant in one cycle.
// - Byte match gives first equal byte position, MSB as 1.
// - No equal byte gives zero; one cycle.
// - Equal test writes 1 on identical words, else 0.
// - Unequal test writes 0 on identical words, else 1.
// - Pattern compares exist only when compare option is 1.
// - Signed upper multiply writes high word of signed product.
// - Low-word multiply writes low word of the product.
module mlp_unit #(
   parameter AREA_SAVING_OPTION = 0,
   parameter HARDWARE_MULTIPLIER_OPTION = `MLP_HWMUL_64,
   parameter PATTERN_COMPARE_OPTION = 1
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Instruction issue
   input wire ins_valid,
   input wire [31:0] ins_word,
   input wire [31:0] first_source_val,
   input wire [31:0] second_source_val,
   // Issue side
   output reg busy_q,
   // Result write back
   output reg res_valid_q,
   output reg [4:0] res_dest_q,
   output reg [31:0] res_data_q,
   output reg illegal_q
);
   localparam MUL_STAGES = AREA_SAVING_OPTION ? `MLP_CYC_AREA : `MLP_CYC_FAST;
   localparam ST_IDLE = 1'b0;
   localparam ST_MUL = 1'b1;
   // Wait count loaded at issue; unused when the multiply is single cycle
   localparam [1:0] MUL_WAIT = (MUL_STAGES > 1) ? MUL_STAGES - 2 : 0;

   wire [5:0] opcode;
   wire [4:0] dest_reg;
   wire [4:0] first_source_reg;
   wire [4:0] second_source_reg;
   wire [1:0] mul_kind;
   wire pcmp_bit;
   wire [31:0] const_operand;
   wire [63:0] product;
   reg prefix_q;
   reg [15:0] prefix_val_q;
   reg state_q;
   reg [1:0] cnt_q;
   reg [4:0] mdest_q;
   reg mhigh_q;
   reg a_signed;
   reg b_signed;
   reg [31:0] mop_b;
   reg is_mul;
   reg hi_sel;
   reg legal;
   reg one_cyc;
   reg [31:0] one_res;
   reg [31:0] byte_pos;
   wire [3:0] byte_eq;
   wire words_eq;
   wire take;

   // ----------------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------------
   mlp_decode u_dec (
      .ins_word(ins_word),
      .prefix_pending(prefix_q),
      .prefix_value(prefix_val_q),
      .opcode(opcode),
      .dest_reg(dest_reg),
      .first_source_reg(first_source_reg),
      .second_source_reg(second_source_reg),
      .mul_kind(mul_kind),
      .pcmp_bit(pcmp_bit),
      .const_operand(const_operand)
   );

   assign take = ins_valid & ~busy_q;

   // ----------------------------------------------------------------------
   // Pattern compare
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_byte
         // Index 0 is the most significant byte
         assign byte_eq[g] = first_source_val[31-8*g -: 8] ==
            second_source_val[31-8*g -: 8];
      end
   endgenerate
   assign words_eq = first_source_val == second_source_val;

   // First match from the MSB wins
   always @* begin
      if (byte_eq[0]) begin
         byte_pos = 32'h1;
      end else if (byte_eq[1]) begin
         byte_pos = 32'h2;
      end else if (byte_eq[2]) begin
         byte_pos = 32'h3;
      end else if (byte_eq[3]) begin
         byte_pos = 32'h4;
      end else begin
         byte_pos = 32'h0;
      end
   end

   // ----------------------------------------------------------------------
   // Operation select
   // ----------------------------------------------------------------------
   always @* begin
      is_mul = 1'b0;
      hi_sel = 1'b0;
      a_signed = 1'b0;
      b_signed = 1'b0;
      mop_b = second_source_val;
      legal = 1'b1;
      one_cyc = 1'b0;
      one_res = 32'h0;
      case (opcode)
         `MLP_OP_MUL: begin
            is_mul = HARDWARE_MULTIPLIER_OPTION > 0;
            case (mul_kind)
               `MLP_MK_HSIGNED: begin
                  hi_sel = 1'b1;
                  a_signed = 1'b1;
                  b_signed = 1'b1;
               end
               `MLP_MK_HMIXED: begin
                  hi_sel = 1'b1;
                  a_signed = 1'b1;
               end
               `MLP_MK_HUNSIGNED: begin
                  hi_sel = 1'b1;
               end
               default: begin
                  hi_sel = 1'b0;
               end
            endcase
            // Upper-word forms need the 64-bit multiplier setting
            if (hi_sel && HARDWARE_MULTIPLIER_OPTION != `MLP_HWMUL_64) begin
               is_mul = 1'b0;
            end
            legal = is_mul;
         end
         `MLP_OP_MULI: begin
            is_mul = HARDWARE_MULTIPLIER_OPTION > 0;
            mop_b = const_operand;
            legal = is_mul;
         end
         `MLP_OP_OR: begin
            if (pcmp_bit) begin
               legal = PATTERN_COMPARE_OPTION == 1;
               one_cyc = legal;
               one_res = byte_pos;
            end else begin
               one_cyc = 1'b1;
               one_res = first_source_val | second_source_val;
            end
         end
         `MLP_OP_ORI: begin
            one_cyc = 1'b1;
            one_res = first_source_val | const_operand;
         end
         `MLP_OP_PCMPEQ: begin
            legal = PATTERN_COMPARE_OPTION == 1 && pcmp_bit;
            one_cyc = legal;
            one_res = {31'h0, words_eq};
         end
         `MLP_OP_PCMPNE: begin
            legal = PATTERN_COMPARE_OPTION == 1 && pcmp_bit;
            one_cyc = legal;
            one_res = {31'h0, ~words_eq};
         end
         `MLP_OP_PREFIX: begin
            // Only supplies the upper half to the next word; no result, not illegal
            legal = 1'b1;
         end
         default: begin
            legal = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Multiplier
   // ----------------------------------------------------------------------
   mlp_mult #(
      .STAGES(MUL_STAGES)
   ) u_mul (
      .clk_sys(clk_sys),
      .op_a(first_source_val),
      .op_b(mop_b),
      .a_signed(a_signed),
      .b_signed(b_signed),
      .product(product)
   );

   // ----------------------------------------------------------------------
   // Prefix tracking: only the word right after the prefix sees it
   // ----------------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (rst) begin
         prefix_q <= 1'b0;
         prefix_val_q <= 16'h0;
      end else if (take) begin
         prefix_q <= opcode == `MLP_OP_PREFIX;
         prefix_val_q <= ins_word[15:0];
      end
   end

   // ----------------------------------------------------------------------
   // Sequencer and result register
   // ----------------------------------------------------------------------
   // Area mode holds busy so the issue side stalls for the extra cycles
   always @(posedge clk_sys) begin
      if (rst) begin
         state_q <= ST_IDLE;
         cnt_q <= 2'h0;
         busy_q <= 1'b0;
         mdest_q <= 5'h0;
         mhigh_q <= 1'b0;
         res_valid_q <= 1'b0;
         res_dest_q <= 5'h0;
         res_data_q <= 32'h0;
         illegal_q <= 1'b0;
      end else begin
         res_valid_q <= 1'b0;
         illegal_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (take && is_mul && MUL_STAGES == 1) begin
                  res_valid_q <= 1'b1;
                  res_dest_q <= dest_reg;
                  res_data_q <= hi_sel ? product[63:32] : product[31:0];
               end else if (take && is_mul) begin
                  state_q <= ST_MUL;
                  busy_q <= 1'b1;
                  cnt_q <= MUL_WAIT;
                  mdest_q <= dest_reg;
                  mhigh_q <= hi_sel;
               end else if (take && one_cyc) begin
                  res_valid_q <= 1'b1;
                  res_dest_q <= dest_reg;
                  res_data_q <= one_res;
               end else if (take && !legal) begin
                  illegal_q <= 1'b1;
               end
            end
            ST_MUL: begin
               if (cnt_q == 2'h0) begin
                  state_q <= ST_IDLE;
                  busy_q <= 1'b0;
                  res_valid_q <= 1'b1;
                  res_dest_q <= mdest_q;
                  res_data_q <= mhigh_q ? product[63:32] : product[31:0];
               end else begin
                  cnt_q <= cnt_q - 2'h1;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               busy_q <= 1'b0;
            end
         endcase
      end
   end
endmodule

// ### design/mlp_map.vh
// Constants for the multiply, logic and pattern compare slice.
// Assumes big-endian bit numbering of the instruction word, bit 0 = MSB.
`ifndef MLP_MAP_VH
`define MLP_MAP_VH

// -------------------------------------------------------------------------
// Opcode field values (instruction bits 0..5)
// -------------------------------------------------------------------------
`define MLP_OP_MUL 6'h10
`define MLP_OP_MULI 6'h18
`define MLP_OP_OR 6'h20
`define MLP_OP_ORI 6'h28
`define MLP_OP_PCMPEQ 6'h22
`define MLP_OP_PCMPNE 6'h23
`define MLP_OP_PREFIX 6'h2c

// -------------------------------------------------------------------------
// Multiply kind in instruction bits 30..31
// -------------------------------------------------------------------------
`define MLP_MK_LOW 2'h0
`define MLP_MK_HSIGNED 2'h1
`define MLP_MK_HMIXED 2'h2
`define MLP_MK_HUNSIGNED 2'h3

// -------------------------------------------------------------------------
// Configuration defaults and timing
// -------------------------------------------------------------------------
`define MLP_HWMUL_64 2
`define MLP_CYC_FAST 1
`define MLP_CYC_AREA 3
`define MLP_CLK_NS 5

`endif

// ### design/mlp_decode.v
// Instruction field split and operand selection for the datapath slice.
// Assumes the word is valid whenever ins_valid is high.
`timescale 1ns/1ps
`include "mlp_map.vh"

module mlp_decode (
   // Instruction
   input wire [31:0] ins_word,
   input wire prefix_pending,
   input wire [15:0] prefix_value,
   // Fields
   output wire [5:0] opcode,
   output wire [4:0] dest_reg,
   output wire [4:0] first_source_reg,
   output wire [4:0] second_source_reg,
   output wire [1:0] mul_kind,
   output wire pcmp_bit,
   output wire [31:0] const_operand
);
   wire [15:0] constant_field;

   // Bit 0 of the word is the MSB, so field n..m maps to [31-n:31-m]
   assign opcode = ins_word[31:26];
   assign dest_reg = ins_word[25:21];
   assign first_source_reg = ins_word[20:16];
   assign second_source_reg = ins_word[15:11];
   assign pcmp_bit = ins_word[10];
   assign mul_kind = ins_word[1:0];
   assign constant_field = ins_word[15:0];

   // Sign extend unless a prefix word just supplied the upper half
   assign const_operand = prefix_pending ? {prefix_value, constant_field} :
      {{16{constant_field[15]}}, constant_field};
endmodule

// ### design/mlp_mult.v
// 32x32 multiplier with selectable operand signedness.
// Assumes the caller holds operands stable only for the start cycle.
`timescale 1ns/1ps
`include "mlp_map.vh"

module mlp_mult #(
   parameter STAGES = 1
) (
   // Clock
   input wire clk_sys,
   // Operands
   input wire [31:0] op_a,
   input wire [31:0] op_b,
   input wire a_signed,
   input wire b_signed,
   // Product, valid STAGES-1 cycles after the operands
   output wire [63:0] product
);
   wire signed [32:0] ext_a;
   wire signed [32:0] ext_b;
   wire signed [65:0] full;
   reg [63:0] pipe_q [0:2];
   integer i;

   // One extra bit per operand covers signed, mixed and unsigned
   assign ext_a = {a_signed & op_a[31], op_a};
   assign ext_b = {b_signed & op_b[31], op_b};
   assign full = ext_a * ext_b;

   // Area mode spreads the product over extra register stages
   always @(posedge clk_sys) begin
      pipe_q[0] <= full[63:0];
      for (i = 1; i < 3; i = i + 1) begin
         pipe_q[i] <= pipe_q[i-1];
      end
   end

   // Pick the stage by elaboration so the one-cycle build never indexes below 0
   generate
      if (STAGES > 1) begin : g_piped
         assign product = pipe_q[STAGES-2];
      end else begin : g_direct
         assign product = full[63:0];
      end
   endgenerate
endmodule

// ### tb/mlp_monitor.sv
// Port assertions for the multiply, logic and pattern compare slice.
// Assumes one clock domain, synchronous active-high reset, bound to mlp_unit.
`timescale 1ns/1ps
`include "mlp_map.vh"
module mlp_monitor #(
   parameter AREA_SAVING_OPTION = 0
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Issue
   input wire ins_valid,
   input wire [31:0] ins_word,
   input wire [31:0] first_source_val,
   input wire [31:0] second_source_val,
   // Results
   input wire busy_q,
   input wire res_valid_q,
   input wire [4:0] res_dest_q,
   input wire [31:0] res_data_q,
   input wire illegal_q
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   localparam int LAT = AREA_SAVING_OPTION ? 3 : 1;
   wire take = ins_valid && !busy_q;
   wire [5:0] opc = ins_word[31:26];
   wire [31:0] av = first_source_val;
   wire [31:0] bv = second_source_val;
   wire [3:0] beq = {av[31:24] == bv[31:24], av[23:16] == bv[23:16],
                     av[15:8] == bv[15:8], av[7:0] == bv[7:0]};
   reg pfx_q;
   // A pending prefix changes the constant, so plain-constant checks skip it
   always @(posedge clk_sys) pfx_q <= rst ? 1'b0 : take ? (opc == `MLP_OP_PREFIX) : pfx_q;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence mul_taken;
      take && opc == `MLP_OP_MUL;
   endsequence
   sequence mul_wait;
      busy_q [*2] ##1 !busy_q;
   endsequence
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_or_value: assert property (take && opc == `MLP_OP_OR && !ins_word[10] |=>
      res_valid_q && res_data_q == ($past(av) | $past(bv)) && res_dest_q == $past(ins_word[25:21]))
      else $error("or result wrong");
   a_ori_value: assert property (take && opc == `MLP_OP_ORI && !pfx_q |=>
      res_data_q == ($past(av) | {{16{$past(ins_word[15])}}, $past(ins_word[15:0])}))
      else $error("or constant result wrong");
   a_eq_value: assert property (take && opc == `MLP_OP_PCMPEQ && ins_word[10] |=>
      res_data_q == {31'h0, $past(av == bv)}) else $error("equal test wrong");
   a_ne_value: assert property (take && opc == `MLP_OP_PCMPNE && ins_word[10] |=>
      res_data_q == {31'h0, $past(av != bv)}) else $error("unequal test wrong");
   a_find_none: assert property (take && opc == `MLP_OP_OR && ins_word[10] && beq == 4'h0 |=>
      res_valid_q && res_data_q == 32'h0) else $error("byte find miss wrong");
   a_find_first: assert property (take && opc == `MLP_OP_OR && ins_word[10] && beq[3] |=>
      res_data_q == 32'h1) else $error("byte find first wrong");
   a_mul_busy: assert property (mul_taken ##0 (LAT == 3) |=> mul_wait)
      else $error("multiply busy window wrong");
   a_mulhu_value: assert property (mul_taken ##0 ins_word[1:0] == `MLP_MK_HUNSIGNED |->
      ##LAT res_valid_q && res_data_q ==
      (({32'h0, $past(av, LAT)} * {32'h0, $past(bv, LAT)}) >> 32)) else $error("mulhu wrong");
   a_prefix_quiet: assert property (take && opc == `MLP_OP_PREFIX |=> !res_valid_q)
      else $error("prefix gave a result");
endmodule
bind mlp_unit mlp_monitor #(.AREA_SAVING_OPTION(AREA_SAVING_OPTION)) u_mon (
   .clk_sys(clk_sys), .rst(rst), .ins_valid(ins_valid), .ins_word(ins_word),
   .first_source_val(first_source_val), .second_source_val(second_source_val),
   .busy_q(busy_q), .res_valid_q(res_valid_q), .res_dest_q(res_dest_q),
   .res_data_q(res_data_q), .illegal_q(illegal_q));

// ### tb/mlp_unit_tb.sv
// Self-checking bench for the multiply, logic and pattern compare slice.
// Assumes the unit is built in area mode, so multiplies take three cycles.
`timescale 1ns/1ps
`include "mlp_map.vh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module mlp_unit_tb;
   logic clk_sys = 0, rst = 1, ins_valid = 0;
   logic [31:0] ins_word = 0, a_val = 0, b_val = 0;
   wire busy_q, res_valid_q, illegal_q;
   wire [4:0] res_dest_q;
   wire [31:0] res_data_q;
   int mismatches = 0, check_count = 0, cyc = 0;
   mlp_unit #(.AREA_SAVING_OPTION(1)) DUT (.clk_sys(clk_sys), .rst(rst),
      .ins_valid(ins_valid), .ins_word(ins_word), .first_source_val(a_val),
      .second_source_val(b_val), .busy_q(busy_q), .res_valid_q(res_valid_q),
      .res_dest_q(res_dest_q), .res_data_q(res_data_q), .illegal_q(illegal_q));
   // ---------------------------------------------------------------
   // Clock, timeout and helpers
   // ---------------------------------------------------------------
   initial forever #2.5 clk_sys = ~clk_sys;
   // Whole run needs about 60 cycles; far beyond that means a hang
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 2000) begin mismatches++; results(); end
   end
   function [31:0] rr(input [5:0] op, input [4:0] d, input [10:0] lo);
      rr = {op, d, 5'd4, 5'd5, lo};
   endfunction
   function [31:0] im(input [5:0] op, input [4:0] d, input [15:0] k);
      im = {op, d, 5'd7, k};
   endfunction
   // Leaves ins_valid high so back-to-back issue never assigns it twice
   task issue(input [31:0] w, a, b);
      ins_word = w; a_val = a; b_val = b; ins_valid = 1;
      @(posedge clk_sys); #1;
   endtask
   task run(input [31:0] w, a, b, e, input int lat);
      int n;
      issue(w, a, b);
      ins_valid = 0;
      n = 1;
      while (res_valid_q !== 1'b1 && n < 8) begin @(posedge clk_sys); #1 n++; end
      `CHK(n, lat)
      `CHK(res_data_q, e)
      `CHK(res_dest_q, w[25:21])
      // Let an edge pass so the next issue never re-drives ins_valid in this step
      @(posedge clk_sys); #1;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task t_mul;
      logic [31:0] a, b;
      logic [63:0] uu, ss, su;
      a = 32'hfffffffe; b = 32'h80000003;
      uu = {32'h0, a} * {32'h0, b};
      ss = {{32{a[31]}}, a} * {{32{b[31]}}, b};
      su = {{32{a[31]}}, a} * {32'h0, b};
      run(rr(`MLP_OP_MUL, 5'd1, 11'h3), a, b, uu[63:32], 3);
      run(rr(`MLP_OP_MUL, 5'd2, 11'h2), a, b, su[63:32], 3);
      run(rr(`MLP_OP_MUL, 5'd3, 11'h1), a, b, ss[63:32], 3);
      run(rr(`MLP_OP_MUL, 5'd4, 11'h0), a, b, uu[31:0], 3);
   endtask
   task t_muli;
      logic [31:0] a;
      a = 32'h00012345;
      run(im(`MLP_OP_MULI, 5'd5, 16'hfffd), a, 0, a * 32'hfffffffd, 3);
      issue(im(`MLP_OP_PREFIX, 5'd0, 16'h0001), 0, 0);
      `CHK(res_valid_q, 1'b0)
      `CHK(illegal_q, 1'b0)
      run(im(`MLP_OP_MULI, 5'd6, 16'h8000), a, 0, a * 32'h00018000, 3);
   endtask
   task t_or;
      issue(rr(`MLP_OP_OR, 5'd7, 11'h0), 32'h12340000, 32'h00005600);
      `CHK(res_data_q, 32'h12345600)
      issue(im(`MLP_OP_ORI, 5'd8, 16'h8001), 32'h12340000, 0);
      `CHK(res_data_q, 32'hffff8001)
      ins_valid = 0;
      @(posedge clk_sys); #1;
      `CHK(res_valid_q, 1'b0)
   endtask
   task t_pcmp;
      logic [31:0] bs [5];
      bs = '{32'h11223344, 32'h00223344, 32'h00003300, 32'h00000044, 32'h44332211};
      for (int i = 0; i < 5; i++) begin
         run(rr(`MLP_OP_OR, 5'd9, 11'h400), 32'h11223344, bs[i], (i + 1) % 5, 1);
      end
      run(rr(`MLP_OP_PCMPEQ, 5'd10, 11'h400), 32'h5a5a0001, 32'h5a5a0001, 1, 1);
      run(rr(`MLP_OP_PCMPEQ, 5'd10, 11'h400), 32'h5a5a0001, 32'h5a5a0000, 0, 1);
      run(rr(`MLP_OP_PCMPNE, 5'd11, 11'h400), 32'h5a5a0001, 32'h5a5a0001, 0, 1);
      run(rr(`MLP_OP_PCMPNE, 5'd11, 11'h400), 32'h5a5a0001, 32'h7a5a0001, 1, 1);
   endtask
   // An instruction offered while the multiply is busy must be dropped
   task t_refuse;
      int n;
      issue(rr(`MLP_OP_MUL, 5'd12, 11'h0), 32'h3, 32'h5);
      issue(rr(`MLP_OP_OR, 5'd13, 11'h0), 32'hf0, 32'h0f);
      ins_valid = 0;
      n = 0;
      repeat (6) begin
         if (res_valid_q === 1'b1) n++;
         @(posedge clk_sys); #1;
      end
      `CHK(n, 1)
      `CHK(res_data_q, 32'hf)
   endtask
   task t_illegal;
      issue(rr(`MLP_OP_PCMPEQ, 5'd14, 11'h0), 1, 1);
      ins_valid = 0;
      `CHK(illegal_q, 1'b1)
      `CHK(res_valid_q, 1'b0)
   endtask
   task results;
      if (mismatches == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      #1 rst = 0;
      t_mul();
      t_muli();
      t_or();
      t_pcmp();
      t_refuse();
      t_illegal();
      results();
   end
endmodule
